// [bench/fsi_core_sva.sv]
// concurrent checks on the status indicator ports
`timescale 1ns/10ps
module fsi_core_sva (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic phy_link_up,
   input wire logic comm_error,
   input wire logic card_access,
   input wire logic unit_error,
   input wire logic unit_warning,
   input wire logic unit_alarm,
   input wire logic network_state_led,
   input wire logic network_error_led,
   input wire logic link_activity_led,
   input wire logic card_access_led,
   input wire logic unit_fault_led,
   input wire logic unit_alarm_led,
   input wire logic sdo_enable,
   input wire logic pdo_in_enable,
   input wire logic pdo_out_enable,
   input wire logic link_established_flag
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // inputs pass two sync flops and one output flop, so four samples settle them
   chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_init_dark: assert property (!sdo_enable |-> !network_state_led)
      else $error("state indicator lit in init");
   chk_pdo_in_gate: assert property (pdo_in_enable |-> sdo_enable)
      else $error("process data open without mailbox");
   chk_pdo_out_gate: assert property (pdo_out_enable |-> pdo_in_enable)
      else $error("master output open before slave input");
   chk_op_gates: assert property (link_established_flag == pdo_out_enable)
      else $error("output gate and link flag disagree");
   chk_op_steady: assert property (link_established_flag |-> network_state_led)
      else $error("state indicator dark while operational");
   chk_err_on: assert property (comm_error [*4] |-> network_error_led)
      else $error("error indicator dark during error");
   chk_err_off: assert property (!comm_error [*4] |-> !network_error_led)
      else $error("error indicator lit without error");
   chk_nolink_dark: assert property (!phy_link_up [*4] |-> !link_activity_led)
      else $error("activity indicator lit without link");
   chk_flag_drop: assert property (!phy_link_up [*5] |-> !link_established_flag)
      else $error("link flag stays after link loss");
   chk_card_follow: assert property (card_access [*4] |-> card_access_led)
      else $error("card indicator dark during access");
   chk_fault_on: assert property (unit_error [*4] |-> unit_fault_led)
      else $error("fault indicator dark on unit error");
   chk_alarm_on: assert property (unit_alarm [*4] |-> unit_alarm_led)
      else $error("alarm indicator dark on alarm");

   cov_op_reached: cover property ($rose(link_established_flag));
   cov_safe_op: cover property (pdo_in_enable && !pdo_out_enable);
   cov_err_seen: cover property ($rose(network_error_led));
endmodule

bind fsi_core fsi_core_sva chk (.*);

// [bench/fsi_slave_model.sv]
// behavioural model of the slave servo amplifiers seen across the network
`timescale 1ns/10ps
module fsi_slave_model (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic link_cmd,
   input  wire logic err_cmd,
   input  wire logic busy_cmd,
   input  wire logic resp_slow,
   input  wire logic sdo_enable,
   output logic      phy_link_up,
   output logic      frame_activity,
   output logic      comm_error,
   output logic      slaves_state_ok
);
   logic [7:0] cnt_reg;
   logic [7:0] lim;

   // slow slaves take long to confirm, so mailbox setup visibly lingers
   assign lim = resp_slow ? 8'h64 : 8'h02;

   // mailbox only
   // frames move only once mailbox traffic is open; a slave in error never confirms
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         phy_link_up     <= 1'b0;
         frame_activity  <= 1'b0;
         comm_error      <= 1'b0;
         slaves_state_ok <= 1'b0;
         cnt_reg         <= 8'h00;
      end else begin
         phy_link_up     <= link_cmd;
         comm_error      <= err_cmd;
         frame_activity  <= busy_cmd && link_cmd && sdo_enable && !frame_activity;
         slaves_state_ok <= sdo_enable && (cnt_reg == lim) && !err_cmd;
         if (!link_cmd)
            cnt_reg <= 8'h00;
         else if (sdo_enable && cnt_reg != lim)
            cnt_reg <= cnt_reg + 8'h01;
      end
   end
endmodule

// [bench/tb_top.sv]
// self-checking bench for the fieldbus status indicator
`timescale 1ns/10ps
`include "fsi_map.vh"
module tb_top;
   logic        core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [3:0]  wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, q;
   logic        link_cmd, err_cmd, busy_cmd, resp_slow;
   logic        card_access, unit_error, unit_warning, unit_alarm;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o, irq, phy_link_up, frame_activity, comm_error, slaves_state_ok;
   wire         network_state_led, network_error_led, link_activity_led, card_access_led;
   wire         unit_fault_led, unit_alarm_led, sdo_enable, pdo_in_enable, pdo_out_enable;
   wire         link_established_flag;
   wire  [3:0]  gates, leds;
   int          err_total, n_checks, cyc_cnt, h;

   assign gates = {link_established_flag, pdo_out_enable, pdo_in_enable, sdo_enable};
   assign leds  = {unit_fault_led, link_activity_led, network_state_led, card_access_led};

   // short counts keep the whole bring-up within a few hundred cycles
   fsi_core #(.INIT_CYCLES(20), .DWELL_CYCLES(10), .TICK_CYCLES(8)) uut (
      .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .phy_link_up(phy_link_up),
      .frame_activity(frame_activity), .comm_error(comm_error), .card_access(card_access),
      .unit_error(unit_error), .unit_warning(unit_warning), .unit_alarm(unit_alarm),
      .slaves_state_ok(slaves_state_ok), .network_state_led(network_state_led),
      .network_error_led(network_error_led), .link_activity_led(link_activity_led),
      .card_access_led(card_access_led), .unit_fault_led(unit_fault_led),
      .unit_alarm_led(unit_alarm_led), .sdo_enable(sdo_enable),
      .pdo_in_enable(pdo_in_enable), .pdo_out_enable(pdo_out_enable),
      .link_established_flag(link_established_flag));

   fsi_slave_model slaves (
      .core_clk(core_clk), .rst(rst), .link_cmd(link_cmd), .err_cmd(err_cmd),
      .busy_cmd(busy_cmd), .resp_slow(resp_slow), .sdo_enable(sdo_enable),
      .phy_link_up(phy_link_up), .frame_activity(frame_activity),
      .comm_error(comm_error), .slaves_state_ok(slaves_state_ok));

   // 8 ns period clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one classic cycle; the wait gives up after 50 edges
   task wb_io(input logic we, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      check(32'(n < 50), 32'h1);
   endtask

   task wait_gates(input logic [3:0] want);
      int n;
      n = 0;
      while (gates !== want && n < 600) begin
         @(posedge core_clk);
         n++;
      end
      check(32'(gates), 32'(want));
   endtask

   // counts the cycles of n in which the chosen indicator is lit
   task lit(input int b, input int n);
      h = 0;
      repeat (n) begin
         @(posedge core_clk);
         if (leds[b] === 1'b1) h++;
      end
   endtask

   task final_report;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // hang guard: the tests need under 3000 cycles
   always @(posedge core_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         err_total++;
         final_report;
      end
   end

   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, link_cmd, err_cmd, busy_cmd} = 6'h00;
      {card_access, unit_error, unit_warning, unit_alarm} = 4'h0;
      wb_adr_i = 4'h0;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      resp_slow = 1'b1;
      rst = 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      wb_io(0, `FSI_OFS_STATUS, 0); check(q, 32'h1);
      check(32'(gates), 32'h0);
      wb_io(0, `FSI_OFS_IRQ_MASK, 0); check(q, 32'h0);
      wb_io(0, `FSI_OFS_CTRL, 0); check(q, 32'h1);
      wb_io(0, 4'h2, 0); check(q, 32'h0);
      $display("test reset done");
      link_cmd <= 1'b1;
      wait_gates(4'h1);
      lit(1, 64); check(32'(h > 0 && h < 64), 32'h1);
      wait_gates(4'h3);
      wait_gates(4'hF);
      check(32'(network_state_led), 32'h1);
      check(32'(link_activity_led), 32'h1);
      wb_io(0, `FSI_OFS_STATUS, 0); check(q, 32'h798);
      wb_io(0, `FSI_OFS_IRQ_STAT, 0); check(q, 32'h1);
      $display("test bring-up done");
      busy_cmd <= 1'b1;
      lit(2, 40); check(32'(h > 0 && h < 40), 32'h1);
      busy_cmd <= 1'b0;
      repeat (48) @(posedge core_clk);
      lit(2, 16); check(32'(h), 32'd16);
      $display("test activity done");
      wb_io(1, `FSI_OFS_IRQ_MASK, 32'h4);
      err_cmd <= 1'b1;
      wait_gates(4'h1);
      check(32'(network_error_led), 32'h1);
      check(32'(irq), 32'h1);
      wb_io(1, `FSI_OFS_IRQ_STAT, 32'hF);
      repeat (2) @(posedge core_clk);
      check(32'(irq), 32'h0);
      wb_io(0, `FSI_OFS_IRQ_STAT, 0); check(q, 32'h0);
      err_cmd <= 1'b0;
      wb_io(1, `FSI_OFS_IRQ_MASK, 32'h0);
      wait_gates(4'hF);
      check(32'(network_error_led), 32'h0);
      check(32'(irq), 32'h0);
      $display("test interrupt done");
      {card_access, unit_error, unit_alarm} <= 3'h7;
      repeat (5) @(posedge core_clk);
      check(32'({card_access_led, unit_fault_led, unit_alarm_led}), 32'h7);
      {card_access, unit_error, unit_alarm} <= 3'h0;
      unit_warning <= 1'b1;
      repeat (5) @(posedge core_clk);
      check(32'({card_access_led, unit_alarm_led}), 32'h0);
      lit(3, 40); check(32'(h > 0 && h < 40), 32'h1);
      unit_warning <= 1'b0;
      $display("test unit done");
      wb_io(1, `FSI_OFS_CTRL, 32'h0);
      wait_gates(4'h0);
      repeat (2) @(posedge core_clk);
      check(32'(network_state_led), 32'h0);
      wb_io(0, `FSI_OFS_CTRL, 0); check(q, 32'h0);
      wb_io(1, `FSI_OFS_CTRL, 32'h1);
      wait_gates(4'hF);
      link_cmd <= 1'b0;
      wait_gates(4'h0);
      repeat (5) @(posedge core_clk);
      check(32'(link_activity_led), 32'h0);
      wb_io(0, `FSI_OFS_IRQ_STAT, 0); check(q & 32'h8, 32'h8);
      $display("test link loss done");
      final_report;
   end
endmodule

// [src/fsi_core.v]
// fieldbus status indicator: state machine, traffic gates, indicators and wishbone registers
//
// Function
// RULE_01: network state indicator is off in init, blinks in pre-operational, single-flashes in safe-operational and is steady in operational.
// RULE_02: network error indicator is lit exactly while a communication error is present.
// RULE_03: link/activity indicator is off while no physical link exists.
// RULE_04: link/activity indicator flickers while linked and frames are moving.
// RULE_05: link/activity indicator is steady on while linked with no frames moving.
// RULE_06: card access indicator is lit only while the memory card is accessed.
// RULE_07: in init all mailbox and process data traffic is blocked both ways.
// RULE_08: in pre-operational mailbox traffic is allowed and process data is blocked both ways.
// RULE_09: in safe-operational mailbox and slave-to-master process data are allowed, master-to-slave blocked.
// RULE_10: state transitions with the slaves run on their own without user action.
// RULE_11: in operational the state indicator is steady and the link established flag is raised.
// RULE_12: after reset communication starts and the link established flag reports the links.
// RULE_13: in operational mailbox and process data are allowed both ways.
// RULE_14: unit fault indicator is steady on error, flickers on warning, and the alarm indicator shows an alarm.
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/10ps
`include "fsi_map.vh"
module fsi_core #(
   parameter INIT_CYCLES  = `FSI_INIT_MS * `FSI_CLK_KHZ,
   parameter DWELL_CYCLES = `FSI_DWELL_MS * `FSI_CLK_KHZ,
   parameter TICK_CYCLES  = `FSI_TICK_MS * `FSI_CLK_KHZ
) (
   input  wire        core_clk,
   input  wire        rst,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg         irq,
   // pins from the network side and the unit
   input  wire        phy_link_up,
   input  wire        frame_activity,
   input  wire        comm_error,
   input  wire        card_access,
   input  wire        unit_error,
   input  wire        unit_warning,
   input  wire        unit_alarm,
   input  wire        slaves_state_ok,
   // indicators, traffic gates and host flag
   output reg         network_state_led,
   output reg         network_error_led,
   output reg         link_activity_led,
   output reg         card_access_led,
   output reg         unit_fault_led,
   output reg         unit_alarm_led,
   output reg         sdo_enable,
   output reg         pdo_in_enable,
   output reg         pdo_out_enable,
   output reg         link_established_flag
);

   // one-hot states of the fieldbus state machine
   localparam [3:0] ST_INIT = 4'h1;
   localparam [3:0] ST_PRE  = 4'h2;
   localparam [3:0] ST_SAFE = 4'h4;
   localparam [3:0] ST_OP   = 4'h8;

   wire [`FSI_IN_W-1:0] pins_raw;
   reg  [`FSI_IN_W-1:0] sync1_reg;
   reg  [`FSI_IN_W-1:0] sync2_reg;
   reg  [3:0]           state_reg;
   reg  [3:0]           state_next;
   reg  [31:0]          wait_reg;
   reg  [31:0]          wait_next;
   reg  [4:0]           act_reg;
   reg                  err_d_reg;
   reg                  link_d_reg;
   reg  [`FSI_IRQ_W-1:0] irq_stat_reg;
   reg  [`FSI_IRQ_W-1:0] irq_mask_reg;
   reg                  run_reg;
   reg  [31:0]          rd_data;
   wire                 tick;
   wire                 blink;
   wire                 flash;
   wire                 flicker;
   wire                 link_s;
   wire                 frame_s;
   wire                 err_s;
   wire                 slaves_ok_s;
   wire                 active;
   wire                 wb_req;
   wire                 wb_commit;
   wire                 wr_stat;
   wire                 wr_mask;
   wire                 wr_ctrl;
   wire [`FSI_IRQ_W-1:0] events;
   wire [`FSI_IRQ_W-1:0] clr_bits;
   wire [31:0]          status_word;

   assign pins_raw = {slaves_state_ok, unit_alarm, unit_warning, unit_error,
                      card_access, comm_error, frame_activity, phy_link_up};

   // two-stage synchroniser per pin; only the second stage is used below
   // a single flop would let a slow pin edge go metastable into the state logic
   genvar gi;
   generate
      for (gi = 0; gi < `FSI_IN_W; gi = gi + 1) begin : g_sync
         always @(posedge core_clk or posedge rst) begin
            if (rst) begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
            end else begin
               sync1_reg[gi] <= pins_raw[gi];
               sync2_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate

   assign link_s      = sync2_reg[`FSI_IN_LINK];
   assign frame_s     = sync2_reg[`FSI_IN_FRAME];
   assign err_s       = sync2_reg[`FSI_IN_COMM_ERR];
   assign slaves_ok_s = sync2_reg[`FSI_IN_SLAVES_OK];

   // shared time base and indicator patterns
   fsi_led_pattern #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_pattern (
      .core_clk (core_clk),
      .rst      (rst),
      .tick     (tick),
      .blink    (blink),
      .flash    (flash),
      .flicker  (flicker)
   );

   // activity stays asserted a few ticks after the last frame so short bursts show
   // trade-off: the hold hides gaps between frames but delays the idle indication
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         act_reg <= 5'h0;
      end else if (frame_s) begin
         act_reg <= `FSI_ACT_HOLD_TICKS;
      end else if (tick && act_reg != 5'h0) begin
         act_reg <= act_reg - 5'h1;
      end
   end
   assign active = (act_reg != 5'h0);

   // next-state logic; link loss and stop outrank the error fallback below,
   // so a dead cable never lingers in a mailbox-only state
   // RULE_10 autonomous stepping: init wait, then advance while the slaves confirm
   // RULE_12 start after reset with no software action; run defaults on
   always @* begin
      state_next = state_reg;
      wait_next  = (wait_reg != 32'h0) ? wait_reg - 32'h1 : 32'h0;
      case (state_reg)
         ST_INIT: begin
            if (link_s && run_reg && wait_reg == 32'h0) begin
               state_next = ST_PRE;
               wait_next  = DWELL_CYCLES;
            end
         end
         ST_PRE: begin
            if (slaves_ok_s && wait_reg == 32'h0) begin
               state_next = ST_SAFE;
               wait_next  = DWELL_CYCLES;
            end
         end
         ST_SAFE: begin
            if (slaves_ok_s && !err_s && wait_reg == 32'h0) begin
               state_next = ST_OP;
            end
         end
         ST_OP: begin
            state_next = ST_OP;
         end
         default: begin
            state_next = ST_INIT;
            wait_next  = INIT_CYCLES;
         end
      endcase
      // a communication error drops back to mailbox-only operation
      if ((state_reg == ST_SAFE || state_reg == ST_OP) && err_s) begin
         state_next = ST_PRE;
         wait_next  = DWELL_CYCLES;
      end
      // losing the link or being stopped restarts from init
      if (state_reg != ST_INIT && (!link_s || !run_reg)) begin
         state_next = ST_INIT;
         wait_next  = INIT_CYCLES;
      end
   end

   // state register; init wait loaded at reset
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_INIT;
         wait_reg  <= INIT_CYCLES;
      end else begin
         state_reg <= state_next;
         wait_reg  <= wait_next;
      end
   end

   // traffic gates, decoded from the state once per cycle
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sdo_enable     <= 1'b0;
         pdo_in_enable  <= 1'b0;
         pdo_out_enable <= 1'b0;
      end else begin
         case (state_reg)
            // RULE_08 mailbox only
            ST_PRE: begin
               sdo_enable     <= 1'b1;
               pdo_in_enable  <= 1'b0;
               pdo_out_enable <= 1'b0;
            end
            // RULE_09 mailbox and inputs
            ST_SAFE: begin
               sdo_enable     <= 1'b1;
               pdo_in_enable  <= 1'b1;
               pdo_out_enable <= 1'b0;
            end
            // RULE_13 everything open
            ST_OP: begin
               sdo_enable     <= 1'b1;
               pdo_in_enable  <= 1'b1;
               pdo_out_enable <= 1'b1;
            end
            // RULE_07 all traffic blocked
            default: begin
               sdo_enable     <= 1'b0;
               pdo_in_enable  <= 1'b0;
               pdo_out_enable <= 1'b0;
            end
         endcase
      end
   end

   // front-panel indicators and host flag
   // every indicator is registered so the panel never sees decode glitches
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         network_state_led     <= 1'b0;
         network_error_led     <= 1'b0;
         link_activity_led     <= 1'b0;
         card_access_led       <= 1'b0;
         unit_fault_led        <= 1'b0;
         unit_alarm_led        <= 1'b0;
         link_established_flag <= 1'b0;
      end else begin
         // RULE_01 state pattern select
         case (state_reg)
            ST_PRE:  network_state_led <= blink;
            ST_SAFE: network_state_led <= flash;
            // RULE_11 steady in operational
            ST_OP:   network_state_led <= 1'b1;
            default: network_state_led <= 1'b0;
         endcase
         // RULE_11 flag follows operational
         // RULE_12 links reported to host
         link_established_flag <= (state_reg == ST_OP);
         // RULE_02 error indicator
         network_error_led <= err_s;
         // RULE_03 off without link
         // RULE_04 flicker on traffic
         // RULE_05 steady when idle
         link_activity_led <= link_s & (active ? flicker : 1'b1);
         // RULE_06 card access
         card_access_led <= sync2_reg[`FSI_IN_CARD];
         // RULE_14 error beats warning
         unit_fault_led <= sync2_reg[`FSI_IN_UNIT_ERR] |
                           (sync2_reg[`FSI_IN_UNIT_WARN] & flicker);
         // RULE_14 alarm indicator
         unit_alarm_led <= sync2_reg[`FSI_IN_UNIT_ALARM];
      end
   end

   // wishbone decode; ack answers one cycle after the request is seen, and a write
   // commits on the edge at which the master samples that ack, while it still holds
   // address and data
   assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_commit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
   // only the low byte lane carries register bits, so sel[0] alone gates a write
   assign wr_stat = wb_commit & wb_sel_i[0] & (wb_adr_i == `FSI_OFS_IRQ_STAT);
   assign wr_mask = wb_commit & wb_sel_i[0] & (wb_adr_i == `FSI_OFS_IRQ_MASK);
   assign wr_ctrl = wb_commit & wb_sel_i[0] & (wb_adr_i == `FSI_OFS_CTRL);

   // events, each one cycle long
   // edges are taken from synced levels, so a pin glitch shorter than a cycle may be lost
   assign events[`FSI_EV_OP_ENTER]  = (state_next == ST_OP) && (state_reg != ST_OP);
   assign events[`FSI_EV_OP_LEAVE]  = (state_reg == ST_OP) && (state_next != ST_OP);
   assign events[`FSI_EV_COMM_ERR]  = err_s & ~err_d_reg;
   assign events[`FSI_EV_LINK_LOST] = link_d_reg & ~link_s;

   // write-one-clear bits; zero outside a committed status write
   assign clr_bits = wr_stat ? wb_dat_i[`FSI_IRQ_W-1:0] : {`FSI_IRQ_W{1'b0}};

   // sticky status: a new event wins over a write-one clear in the same cycle
   // irq is registered, so it trails a status or mask change by one cycle
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         err_d_reg    <= 1'b0;
         link_d_reg   <= 1'b0;
         irq_stat_reg <= {`FSI_IRQ_W{1'b0}};
         irq_mask_reg <= `FSI_IRQ_MASK_RST;
         run_reg      <= `FSI_CTRL_RST;
         irq          <= 1'b0;
      end else begin
         err_d_reg    <= err_s;
         link_d_reg   <= link_s;
         irq_stat_reg <= (irq_stat_reg & ~clr_bits) | events;
         if (wr_mask) begin
            irq_mask_reg <= wb_dat_i[`FSI_IRQ_W-1:0];
         end
         if (wr_ctrl) begin
            run_reg <= wb_dat_i[`FSI_CTRL_RUN];
         end
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // status snapshot; link and error bits show synced pins, activity the tick-held frame pin, not the leds
   assign status_word = {21'h0, link_established_flag, pdo_out_enable, pdo_in_enable,
                         sdo_enable, err_s, active, link_s, state_reg};

   // read mux; unmapped offsets read zero and are still acknowledged
   always @* begin
      case (wb_adr_i)
         `FSI_OFS_STATUS:   rd_data = status_word;
         `FSI_OFS_IRQ_STAT: rd_data = {28'h0, irq_stat_reg};
         `FSI_OFS_IRQ_MASK: rd_data = {28'h0, irq_mask_reg};
         `FSI_OFS_CTRL:     rd_data = {31'h0, run_reg};
         default:           rd_data = 32'h0;
      endcase
   end

   // single-cycle ack, dropped the cycle after it is given
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_data : 32'h0;
      end
   end

endmodule

// [src/fsi_led_pattern.v]
// time base and blink, single-flash and flicker patterns for the indicators
`timescale 1ns/10ps
`include "fsi_map.vh"
module fsi_led_pattern #(
   parameter TICK_CYCLES = `FSI_TICK_MS * `FSI_CLK_KHZ
) (
   input  wire       core_clk,
   input  wire       rst,
   output reg        tick,
   output reg        blink,
   output reg        flash,
   output reg        flicker
);

   reg [31:0] div_reg;
   reg [4:0]  phase_reg;

   // base tick divider; one tick pulse per period
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_reg <= 32'h0;
         tick    <= 1'b0;
      end else if (div_reg == TICK_CYCLES - 1) begin
         div_reg <= 32'h0;
         tick    <= 1'b1;
      end else begin
         div_reg <= div_reg + 32'h1;
         tick    <= 1'b0;
      end
   end

   // phase walks one pattern frame; blink and flash derived from it stay in step, flicker toggles on the tick
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         phase_reg <= 5'h0;
         blink     <= 1'b0;
         flash     <= 1'b0;
         flicker   <= 1'b0;
      end else begin
         if (tick) begin
            phase_reg <= (phase_reg == `FSI_FRAME_LAST) ? 5'h0 : phase_reg + 5'h1;
            flicker   <= ~flicker;
         end
         blink <= ~phase_reg[`FSI_BLINK_BIT];
         flash <= (phase_reg <= `FSI_FLASH_LAST);
      end
   end

endmodule

// [src/fsi_map.vh]
// register map, field positions, reset values and timing constants of the status indicator
`ifndef FSI_MAP_VH
`define FSI_MAP_VH

// register byte offsets (word aligned)
`define FSI_ADDR_W          4
`define FSI_OFS_STATUS      4'h0
`define FSI_OFS_IRQ_STAT    4'h4
`define FSI_OFS_IRQ_MASK    4'h8
`define FSI_OFS_CTRL        4'hC

// status register fields
`define FSI_ST_STATE_LSB    0
`define FSI_ST_STATE_MSB    3
`define FSI_ST_LINK         4
`define FSI_ST_ACTIVITY     5
`define FSI_ST_COMM_ERR     6
`define FSI_ST_SDO          7
`define FSI_ST_PDO_IN       8
`define FSI_ST_PDO_OUT      9
`define FSI_ST_FLAG         10

// interrupt events
`define FSI_IRQ_W           4
`define FSI_EV_OP_ENTER     0
`define FSI_EV_OP_LEAVE     1
`define FSI_EV_COMM_ERR     2
`define FSI_EV_LINK_LOST    3
`define FSI_IRQ_MASK_RST    4'h0

// control register
`define FSI_CTRL_RUN        0
`define FSI_CTRL_RST        1'h1

// synchronised input bits
`define FSI_IN_W            8
`define FSI_IN_LINK         0
`define FSI_IN_FRAME        1
`define FSI_IN_COMM_ERR     2
`define FSI_IN_CARD         3
`define FSI_IN_UNIT_ERR     4
`define FSI_IN_UNIT_WARN    5
`define FSI_IN_UNIT_ALARM   6
`define FSI_IN_SLAVES_OK    7

// timing: clock in kHz and times in ms
`define FSI_CLK_KHZ         125000
`define FSI_TICK_MS         50
`define FSI_INIT_MS         10
`define FSI_DWELL_MS        2
`define FSI_ACT_HOLD_TICKS  5'h02
`define FSI_FRAME_LAST      5'h17
`define FSI_BLINK_BIT       2
`define FSI_FLASH_LAST      5'h03

`endif
